// ---- pid_alarm_monitor.sv ----
`default_nettype none

// Notes on behaviour
// - Feedback smoothed, time constant 0 to 900 s.
// - Integrator frozen while error exceeds band.
// - Mode 0: warn outside absolute limits.
// - Mode 4: warn outside command-relative limits.
// - Mode bits: hold, latch, error type.
// - Hold: suppressed until range left once.
// - Latch: warning stays on after leaving.
// - Latch cleared only by reset command.
// - Thresholds are percent of feedback scale.
// - Output driven only when selector is 42.

module pid_alarm_monitor #(
   parameter int CTRL_CYCLES = pid_alarm_pkg::CTRL_CYCLES
) (
   input wire logic pclk, // APB clock, 125 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic [15:0] feedback_value, // Sensor feedback, full scale 10000.
   input wire logic [15:0] command_value, // Command from the same clock domain.
   input wire logic reset_terminal, // Reset terminal command pin, active high.
   output logic process_warning_out, // Process warning on the digital output.
   output logic integrator_freeze, // High while the integrator must hold.
   output logic irq // Level interrupt.
);

   // ----------------------------------------------------------------
   // State and decode
   // ----------------------------------------------------------------
   pid_alarm_pkg::mon_state_s st_ff, nxt_st; // Whole block state.
   logic [15:0] pv_filt; // Filtered feedback.
   logic setup; // APB setup phase.
   logic wr_acc; // APB write taking effect.
   logic mapped; // Address decodes to a register.
   logic signed [17:0] pv; // Filtered feedback, signed.
   logic signed [17:0] cmd; // Command, signed.
   logic signed [17:0] hi_cnt; // High threshold in counts.
   logic signed [17:0] lo_cnt; // Low threshold in counts.
   logic signed [17:0] hi_lim; // Upper comparison limit.
   logic signed [17:0] lo_lim; // Lower comparison limit.
   logic signed [17:0] err; // Command minus feedback.
   logic [17:0] err_mag; // Error magnitude.
   logic in_range; // Feedback inside the alarm range.
   logic clr_req; // Reset command from keypad or terminal.
   logic raw_warn; // Warning before latching.

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign prdata = st_ff.prdata;
   assign pslverr = st_ff.pslverr;
   assign process_warning_out = st_ff.out;
   assign integrator_freeze = st_ff.freeze;
   assign irq = |(st_ff.irq_status & st_ff.irq_mask);

   // Addresses that hold a register; anything else answers with pslverr.
   always_comb begin
      unique case (paddr)
         pid_alarm_pkg::REG_FILTER_TC, pid_alarm_pkg::REG_FREEZE_BAND, pid_alarm_pkg::REG_WARN_MODE,
         pid_alarm_pkg::REG_HIGH_TH, pid_alarm_pkg::REG_LOW_TH, pid_alarm_pkg::REG_OUT_FUNC,
         pid_alarm_pkg::REG_CONTROL, pid_alarm_pkg::REG_STATE, pid_alarm_pkg::REG_FEEDBACK,
         pid_alarm_pkg::REG_IRQ_STATUS, pid_alarm_pkg::REG_IRQ_MASK: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Feedback filter
   // ----------------------------------------------------------------
   pid_feedback_filter #(
      .W(pid_alarm_pkg::FB_W)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .tick(st_ff.tick),
      .tc(st_ff.cfg.filter_tc),
      .din(st_ff.fb_s2),
      .dout(pv_filt)
   );

   // ----------------------------------------------------------------
   // Comparisons
   // ----------------------------------------------------------------
   // Thresholds are whole percent of full scale, so one percent is 100 counts.
   // Signed 18-bit arithmetic keeps command minus threshold from wrapping.
   always_comb begin
      pv = $signed({2'b00, pv_filt});
      cmd = $signed({2'b00, command_value});
      hi_cnt = $signed(18'({10'h000, st_ff.cfg.high_th} * pid_alarm_pkg::PCT_COUNTS));
      lo_cnt = $signed(18'({10'h000, st_ff.cfg.low_th} * pid_alarm_pkg::PCT_COUNTS));
      if (st_ff.cfg.mode[pid_alarm_pkg::MODE_ERR_BIT]) begin
         hi_lim = cmd + hi_cnt;
         lo_lim = cmd - lo_cnt;
      end else begin
         hi_lim = hi_cnt;
         lo_lim = lo_cnt;
      end
      in_range = (pv < lo_lim) || (pv > hi_lim);
      err = cmd - pv;
      err_mag = err[17] ? 18'(-err) : 18'(err);
   end

   // The keypad key and the terminal clear a latch the same way a fault reset does.
   assign clr_req = st_ff.kp_reset || st_ff.rst_s2;

   // Hold suppresses the warning until the quantity has been out of range once.
   assign raw_warn = in_range && (st_ff.armed || !st_ff.cfg.mode[pid_alarm_pkg::MODE_HOLD_BIT]);

   localparam int IRQ_W_LOCAL = pid_alarm_pkg::IRQ_W; // Status width used in slices.

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [IRQ_W_LOCAL-1:0] set_ev;
      set_ev = '0;
      nxt_st = st_ff;
      // Synchronisers: the first stage feeds only the second.
      nxt_st.fb_s1 = feedback_value;
      nxt_st.fb_s2 = st_ff.fb_s1;
      nxt_st.rst_s1 = reset_terminal;
      nxt_st.rst_s2 = st_ff.rst_s1;
      nxt_st.kp_reset = 1'b0;
      // Control cycle divider.
      if (st_ff.div_cnt >= 24'(CTRL_CYCLES - 1)) begin
         nxt_st.div_cnt = 24'h000000;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.div_cnt = st_ff.div_cnt + 24'h000001;
         nxt_st.tick = 1'b0;
      end
      // Supervision runs only on control cycle ticks.
      if (st_ff.tick) begin
         if (!in_range) begin
            nxt_st.armed = 1'b1;
         end
         nxt_st.freeze = err_mag > 18'({10'h000, st_ff.cfg.band} * pid_alarm_pkg::PCT_COUNTS);
         if (raw_warn && st_ff.cfg.mode[pid_alarm_pkg::MODE_LATCH_BIT]) begin
            nxt_st.latched = 1'b1;
         end
         nxt_st.warn = raw_warn || nxt_st.latched;
      end
      // A reset clears the latch; a tick that sets it again in the same cycle wins.
      if (clr_req && !(st_ff.tick && raw_warn && st_ff.cfg.mode[pid_alarm_pkg::MODE_LATCH_BIT])) begin
         nxt_st.latched = 1'b0;
         if (!st_ff.tick) begin
            nxt_st.warn = st_ff.warn && !st_ff.latched;
         end
      end
      // Output terminal carries the warning only when assigned code 42.
      nxt_st.out = nxt_st.warn && (st_ff.cfg.out_func == pid_alarm_pkg::OUT_FUNC_WARN);
      // Interrupt events.
      set_ev[pid_alarm_pkg::IRQ_WARN_BIT] = nxt_st.warn && !st_ff.warn;
      set_ev[pid_alarm_pkg::IRQ_FREEZE_BIT] = nxt_st.freeze && !st_ff.freeze;
      set_ev[pid_alarm_pkg::IRQ_UNLATCH_BIT] = st_ff.latched && !nxt_st.latched;
      // APB writes take effect in the access phase.
      if (wr_acc) begin
         unique case (paddr)
            pid_alarm_pkg::REG_FILTER_TC: begin
               // Values past 900.0 s are clamped to FILTER_TC_MAX, the longest time constant.
               nxt_st.cfg.filter_tc = (pwdata[15:0] > pid_alarm_pkg::FILTER_TC_MAX) ?
                                      pid_alarm_pkg::FILTER_TC_MAX : pwdata[15:0];
            end
            pid_alarm_pkg::REG_FREEZE_BAND: begin
               nxt_st.cfg.band = (pwdata[7:0] > pid_alarm_pkg::PCT_MAX) ? pid_alarm_pkg::PCT_MAX : pwdata[7:0];
            end
            pid_alarm_pkg::REG_WARN_MODE: begin
               nxt_st.cfg.mode = pwdata[2:0];
            end
            pid_alarm_pkg::REG_HIGH_TH: begin
               nxt_st.cfg.high_th = (pwdata[7:0] > pid_alarm_pkg::PCT_MAX) ? pid_alarm_pkg::PCT_MAX : pwdata[7:0];
            end
            pid_alarm_pkg::REG_LOW_TH: begin
               nxt_st.cfg.low_th = (pwdata[7:0] > pid_alarm_pkg::PCT_MAX) ? pid_alarm_pkg::PCT_MAX : pwdata[7:0];
            end
            pid_alarm_pkg::REG_OUT_FUNC: begin
               nxt_st.cfg.out_func = pwdata[7:0];
            end
            pid_alarm_pkg::REG_CONTROL: begin
               nxt_st.kp_reset = pwdata[pid_alarm_pkg::CTRL_RESET_BIT];
            end
            pid_alarm_pkg::REG_IRQ_MASK: begin
               nxt_st.irq_mask = pwdata[IRQ_W_LOCAL-1:0];
            end
            default: begin
               // Read-only, write-one-to-clear or unmapped: nothing stored here.
            end
         endcase
      end
      // Sticky status: write one clears, a new event in the same cycle wins.
      if (wr_acc && paddr == pid_alarm_pkg::REG_IRQ_STATUS) begin
         nxt_st.irq_status = (st_ff.irq_status & ~pwdata[IRQ_W_LOCAL-1:0]) | set_ev;
      end else begin
         nxt_st.irq_status = st_ff.irq_status | set_ev;
      end
      // Read data and error are captured in the setup phase for a zero-wait access.
      if (setup) begin
         nxt_st.pslverr = !mapped;
         unique case (paddr)
            pid_alarm_pkg::REG_FILTER_TC: nxt_st.prdata = {16'h0000, st_ff.cfg.filter_tc};
            pid_alarm_pkg::REG_FREEZE_BAND: nxt_st.prdata = {24'h000000, st_ff.cfg.band};
            pid_alarm_pkg::REG_WARN_MODE: nxt_st.prdata = {29'h00000000, st_ff.cfg.mode};
            pid_alarm_pkg::REG_HIGH_TH: nxt_st.prdata = {24'h000000, st_ff.cfg.high_th};
            pid_alarm_pkg::REG_LOW_TH: nxt_st.prdata = {24'h000000, st_ff.cfg.low_th};
            pid_alarm_pkg::REG_OUT_FUNC: nxt_st.prdata = {24'h000000, st_ff.cfg.out_func};
            pid_alarm_pkg::REG_STATE: begin
               nxt_st.prdata = {27'h0000000, st_ff.out, st_ff.armed, st_ff.latched, st_ff.freeze, st_ff.warn};
            end
            pid_alarm_pkg::REG_FEEDBACK: nxt_st.prdata = {16'h0000, pv_filt};
            pid_alarm_pkg::REG_IRQ_STATUS: nxt_st.prdata = {29'h00000000, st_ff.irq_status};
            pid_alarm_pkg::REG_IRQ_MASK: nxt_st.prdata = {29'h00000000, st_ff.irq_mask};
            default: nxt_st.prdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Hold restarts from power-up: armed clears only under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.cfg.filter_tc <= pid_alarm_pkg::RST_FILTER_TC;
         st_ff.cfg.band <= pid_alarm_pkg::RST_FREEZE_BAND;
         st_ff.cfg.mode <= pid_alarm_pkg::RST_WARN_MODE;
         st_ff.cfg.high_th <= pid_alarm_pkg::RST_HIGH_TH;
         st_ff.cfg.low_th <= pid_alarm_pkg::RST_LOW_TH;
         st_ff.cfg.out_func <= pid_alarm_pkg::RST_OUT_FUNC;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      st_ff.tick |=> (integrator_freeze == ($past(err_mag) > 18'({10'h000, $past(st_ff.cfg.band)} * 18'h00064)));
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze does not follow band");

   property p_abs_low;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.tick && st_ff.cfg.mode == 3'h0 && pv < lo_cnt) |=> st_ff.warn;
   endproperty
   a_abs_low: assert property (p_abs_low) else $error("absolute low warning missing");

   property p_err_high;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.tick && st_ff.cfg.mode == 3'h4 && pv > cmd + hi_cnt) |=> st_ff.warn;
   endproperty
   a_err_high: assert property (p_err_high) else $error("error high warning missing");

   property p_no_latch;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.tick && !st_ff.cfg.mode[1] && !in_range) |=> !st_ff.warn;
   endproperty
   a_no_latch: assert property (p_no_latch) else $error("warning stayed without latch");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      ($rose(st_ff.warn) && st_ff.cfg.mode[0]) |-> $past(st_ff.armed);
   endproperty
   a_hold: assert property (p_hold) else $error("warning rose before hold released");

   property p_latch_keep;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.latched && !clr_req) |=> (st_ff.latched && st_ff.warn);
   endproperty
   a_latch_keep: assert property (p_latch_keep) else $error("latched warning dropped");

   property p_unlatch;
      @(posedge pclk) disable iff (!presetn)
      $fell(st_ff.latched) |-> $past(clr_req);
   endproperty
   a_unlatch: assert property (p_unlatch) else $error("latch cleared without reset");

   property p_high_pct;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.tick && st_ff.cfg.mode == 3'h0 && pv > $signed({10'h000, st_ff.cfg.high_th}) * 18'sh00064)
      |=> st_ff.warn;
   endproperty
   a_high_pct: assert property (p_high_pct) else $error("high percent threshold missed");

   property p_out_gate;
      @(posedge pclk) disable iff (!presetn)
      process_warning_out |-> ($past(st_ff.cfg.out_func) == 8'h2A && st_ff.warn);
   endproperty
   a_out_gate: assert property (p_out_gate) else $error("output driven without code 42");

   property p_tick_only;
      @(posedge pclk) disable iff (!presetn)
      !st_ff.tick |=> $stable(integrator_freeze);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("freeze changed between ticks");

endmodule

`default_nettype wire

// ---- pid_alarm_pkg.sv ----
`default_nettype none

package pid_alarm_pkg;

   // ----------------------------------------------------------------
   // Widths and scaling
   // ----------------------------------------------------------------
   localparam int FB_W = 16;                      // Feedback and command word width.
   localparam int FRAC_W = 4;                     // Fraction bits kept inside the filter.
   localparam int ALPHA_SHIFT = 4;                // Filter gain is 1/16 per filter step.
   localparam logic [17:0] PCT_COUNTS = 18'h00064; // Counts per percent (full scale 10000 = 100 %).
   localparam logic [15:0] FILTER_TC_MAX = 16'h2328; // 900.0 s in tenths.
   localparam logic [7:0] PCT_MAX = 8'hC8;        // 200 %.
   localparam logic [7:0] OUT_FUNC_WARN = 8'h2A;  // Output function code 42.
   localparam logic [23:0] CYCLES_PER_TENTH = 24'h000064; // Control cycles in 0.1 s.

   // ----------------------------------------------------------------
   // Control cycle timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;              // 125 MHz.
   localparam int CTRL_PERIOD_NS = 1000000;       // 1 ms control cycle.
   localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_FILTER_TC = 8'h00;
   localparam logic [7:0] REG_FREEZE_BAND = 8'h04;
   localparam logic [7:0] REG_WARN_MODE = 8'h08;
   localparam logic [7:0] REG_HIGH_TH = 8'h0C;
   localparam logic [7:0] REG_LOW_TH = 8'h10;
   localparam logic [7:0] REG_OUT_FUNC = 8'h14;
   localparam logic [7:0] REG_CONTROL = 8'h18;
   localparam logic [7:0] REG_STATE = 8'h1C;
   localparam logic [7:0] REG_FEEDBACK = 8'h20;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h24;
   localparam logic [7:0] REG_IRQ_MASK = 8'h28;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_FILTER_TC = 16'h0000;
   localparam logic [7:0] RST_FREEZE_BAND = 8'hC8;
   localparam logic [2:0] RST_WARN_MODE = 3'h0;
   localparam logic [7:0] RST_HIGH_TH = 8'h64;
   localparam logic [7:0] RST_LOW_TH = 8'h00;
   localparam logic [7:0] RST_OUT_FUNC = 8'h00;
   localparam int MODE_HOLD_BIT = 0;
   localparam int MODE_LATCH_BIT = 1;
   localparam int MODE_ERR_BIT = 2;
   localparam int CTRL_RESET_BIT = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_WARN_BIT = 0;
   localparam int IRQ_FREEZE_BIT = 1;
   localparam int IRQ_UNLATCH_BIT = 2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] filter_tc;
      logic [7:0] band;
      logic [2:0] mode;
      logic [7:0] high_th;
      logic [7:0] low_th;
      logic [7:0] out_func;
   } cfg_s;

   typedef struct packed {
      cfg_s cfg;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0] prdata;
      logic pslverr;
      logic [23:0] div_cnt;
      logic tick;
      logic kp_reset;
      logic [FB_W-1:0] fb_s1;
      logic [FB_W-1:0] fb_s2;
      logic rst_s1;
      logic rst_s2;
      logic armed;
      logic latched;
      logic warn;
      logic freeze;
      logic out;
   } mon_state_s;

   typedef struct packed {
      logic [FB_W+FRAC_W-1:0] acc;
      logic [23:0] cnt;
   } filt_state_s;

endpackage

`default_nettype wire

// ---- pid_feedback_filter.sv ----
`default_nettype none

module pid_feedback_filter #(
   parameter int W = 16
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic tick, // Control cycle enable pulse.
   input wire logic [15:0] tc, // Time constant in tenths of a second.
   input wire logic [W-1:0] din, // Raw feedback.
   output logic [W-1:0] dout // Filtered feedback.
);

   // ----------------------------------------------------------------
   // First-order smoothing
   // ----------------------------------------------------------------
   // A fixed gain of 1/16 is applied every tc*100/16 control cycles, which
   // gives a time constant of tc tenths of a second without a divider.
   pid_alarm_pkg::filt_state_s st_ff, nxt_st;
   logic [23:0] interval; // Control cycles between filter steps.
   logic signed [W+pid_alarm_pkg::FRAC_W+1:0] diff; // Target minus accumulator.

   assign interval = 24'(({8'h00, tc} * pid_alarm_pkg::CYCLES_PER_TENTH) >> pid_alarm_pkg::ALPHA_SHIFT);
   assign diff = $signed({2'b00, din, {pid_alarm_pkg::FRAC_W{1'b0}}}) - $signed({2'b00, st_ff.acc});
   assign dout = st_ff.acc[W+pid_alarm_pkg::FRAC_W-1:pid_alarm_pkg::FRAC_W];

   // Step the accumulator on the paced control ticks.
   always_comb begin
      nxt_st = st_ff;
      if (tick) begin
         if (interval == 24'h000000) begin
            nxt_st.acc = {din, {pid_alarm_pkg::FRAC_W{1'b0}}};
            nxt_st.cnt = 24'h000000;
         end else if (st_ff.cnt >= interval - 24'h000001) begin
            nxt_st.cnt = 24'h000000;
            nxt_st.acc = (W + pid_alarm_pkg::FRAC_W)'($signed({2'b00, st_ff.acc})
                         + (diff >>> pid_alarm_pkg::ALPHA_SHIFT));
         end else begin
            nxt_st.cnt = st_ff.cnt + 24'h000001;
         end
      end
   end

   // Single state register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // With a zero time constant the filter copies the input on every control tick and holds it between ticks.
   property p_passthru;
      @(posedge pclk) disable iff (!presetn)
      (tick && tc == 16'h0000) |=> (dout == $past(din));
   endproperty
   a_passthru: assert property (p_passthru) else $error("filter did not pass input through");

endmodule

`default_nettype wire

// ---- pid_sensor_model.sv ----
`default_nettype none

// ----------------------------------------------------------------
// Sensor, command source and reset terminal facing the monitor
// ----------------------------------------------------------------
module pid_sensor_model (
   input wire logic [15:0] level, // Process level to present.
   input wire logic [15:0] target, // Command to present.
   input wire logic clear_req, // Operator asks for an alarm reset.
   output logic [15:0] feedback_value, // Sensor word, 10000 counts full scale.
   output logic [15:0] command_value, // Command word, same scale.
   output logic reset_terminal // Reset terminal, active high level.
);
   timeunit 1ns;
   timeprecision 1ps;
   // The sensor is an analogue source, so its word follows the process level at once.
   assign feedback_value = level;
   assign command_value = target;
   // The terminal is a level held by the operator for as long as needed.
   assign reset_terminal = clear_req;
endmodule

`default_nettype wire

// ---- pid_feedback_alarm_monitor_tb_top.sv ----
`default_nettype none

module pid_feedback_alarm_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clear_req = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err, process_warning_out, integrator_freeze, irq, reset_terminal;
   logic [15:0] level = 16'h0000, target = 16'h1388, feedback_value, command_value;
   int n_errors = 0, tests_run = 0;
   always #4 pclk = ~pclk; // 125 MHz.
   pid_sensor_model sensor (.level(level), .target(target), .clear_req(clear_req),
      .feedback_value(feedback_value), .command_value(command_value), .reset_terminal(reset_terminal));
   // A short control cycle keeps every settle wait small.
   pid_alarm_monitor #(.CTRL_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .feedback_value(feedback_value), .command_value(command_value), .reset_terminal(reset_terminal),
      .process_warning_out(process_warning_out), .integrator_freeze(integrator_freeze), .irq(irq));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   // One APB transfer; an idle cycle follows so no strobe is driven twice in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         results();
      end
      @(posedge pclk);
   endtask
   // Forty cycles cover the pin path, several ticks and the output register.
   task automatic lv(input logic [15:0] f, input logic [15:0] c);
      level <= f;
      target <= c;
      repeat (40) @(posedge pclk);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] a [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28, 8'h3C};
      logic [31:0] e [8] = '{32'h0, 32'hC8, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};
      foreach (a[i]) begin
         apb(1'b0, a[i], 32'h0);
         chk("reset value", e[i], q);
         chk("bus error", {31'h0, i == 7}, {31'h0, err});
      end
      apb(1'b1, pid_alarm_pkg::REG_HIGH_TH, 32'hFF);
      apb(1'b0, pid_alarm_pkg::REG_HIGH_TH, 32'h0);
      chk("clamped limit", 32'hC8, q);
      apb(1'b1, pid_alarm_pkg::REG_FILTER_TC, 32'hFFFF);
      apb(1'b0, pid_alarm_pkg::REG_FILTER_TC, 32'h0);
      chk("clamped time constant", 32'h2328, q);
      apb(1'b1, pid_alarm_pkg::REG_FILTER_TC, 32'h0);
   endtask
   // Power-on again with the error-type check already in alarm, so hold must suppress it.
   // The mode is written before the first control tick, which would otherwise arm the hold.
   task automatic t_hold();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, pid_alarm_pkg::REG_WARN_MODE, 32'h5);
      apb(1'b1, pid_alarm_pkg::REG_OUT_FUNC, 32'h2A);
      lv(16'h0000, 16'h1388);
      chk("held warning", 32'h0, {31'h0, process_warning_out});
      lv(16'h1388, 16'h1388);
      lv(16'h0000, 16'h1388);
      chk("armed warning", 32'h1, {31'h0, process_warning_out});
   endtask
   // Levels alternate just outside and exactly on a limit, so strictness shows.
   task automatic sweep(input logic [31:0] m, input logic [31:0] hi, input logic [31:0] lo,
                        input logic [15:0] c, input logic [3:0][15:0] l);
      apb(1'b1, pid_alarm_pkg::REG_WARN_MODE, m);
      apb(1'b1, pid_alarm_pkg::REG_HIGH_TH, hi);
      apb(1'b1, pid_alarm_pkg::REG_LOW_TH, lo);
      for (int i = 0; i < 4; i++) begin
         lv(l[3-i], c);
         chk("warning output", 32'(i % 2 == 0), {31'h0, process_warning_out});
         chk("in-range indication", 32'(i % 2 != 0), {31'h0, !process_warning_out});
      end
   endtask
   task automatic t_gate();
      apb(1'b1, pid_alarm_pkg::REG_OUT_FUNC, 32'h29);
      lv(16'h1771, 16'h1388);
      apb(1'b0, pid_alarm_pkg::REG_STATE, 32'h0);
      chk("internal warning", 32'h1, {31'h0, q[0]});
      chk("gated output", 32'h0, {31'h0, process_warning_out});
      apb(1'b1, pid_alarm_pkg::REG_OUT_FUNC, 32'h2A);
   endtask
   // Latch cleared once by the terminal and once by the keypad command, with interrupts.
   task automatic t_latch();
      apb(1'b1, pid_alarm_pkg::REG_WARN_MODE, 32'h2);
      apb(1'b1, pid_alarm_pkg::REG_HIGH_TH, 32'h3C);
      apb(1'b1, pid_alarm_pkg::REG_LOW_TH, 32'h14);
      for (int k = 0; k < 2; k++) begin
         lv(16'h1B58, 16'h1388);
         lv(16'h1388, 16'h1388);
         chk("latched warning", 32'h1, {31'h0, process_warning_out});
         apb(1'b1, pid_alarm_pkg::REG_IRQ_STATUS, 32'h7);
         apb(1'b1, pid_alarm_pkg::REG_IRQ_MASK, 32'h4);
         chk("quiet irq", 32'h0, {31'h0, irq});
         clear_req <= (k == 0);
         if (k == 1) apb(1'b1, pid_alarm_pkg::REG_CONTROL, 32'h1);
         lv(16'h1388, 16'h1388);
         clear_req <= 1'b0;
         lv(16'h1388, 16'h1388);
         chk("cleared warning", 32'h0, {31'h0, process_warning_out});
         chk("raised irq", 32'h1, {31'h0, irq});
         apb(1'b1, pid_alarm_pkg::REG_IRQ_MASK, 32'h0);
         chk("masked irq", 32'h0, {31'h0, irq});
         apb(1'b1, pid_alarm_pkg::REG_IRQ_STATUS, 32'h4);
         apb(1'b0, pid_alarm_pkg::REG_IRQ_STATUS, 32'h0);
         chk("cleared status", 32'h0, {29'h0, q[2:0] & 3'h4});
      end
   endtask
   task automatic t_freeze();
      apb(1'b1, pid_alarm_pkg::REG_FREEZE_BAND, 32'h0A);
      lv(16'h1771, 16'h1388);
      chk("frozen", 32'h1, {31'h0, integrator_freeze});
      lv(16'h1770, 16'h1388);
      chk("running", 32'h0, {31'h0, integrator_freeze});
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_hold();
      sweep(32'h0, 32'h3C, 32'h14, 16'h1388, {16'h1771, 16'h1770, 16'h07CF, 16'h07D0});
      sweep(32'h4, 32'h0A, 32'h0A, 16'h0BB8, {16'h0FA1, 16'h0FA0, 16'h07CF, 16'h07D0});
      t_gate();
      t_latch();
      t_freeze();
      results();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      results();
   end
endmodule

`default_nettype wire
